// ==== core/ebw_pkg.sv ====
// Constants and types shared by the external bus write strobe and address decode block.
//
// Summary of operation
// - Combined write strobe is low only while an external write cycle runs.
// - Strobe pin held high by outside circuitry during reset selects PLL bypass.
// - In PLL bypass the phase clocks run at half the oscillator input rate.
// - Configuration bit 2 set selects combined strobe, clear selects low-byte strobe.
// - On 16-bit bus, low-byte strobe fires for low-byte and word writes only.
// - On 8-bit bus, low-byte strobe fires for every external write.
// - The first fetch after any reset is from address 2080.
// - Addresses 8000 to FFFF are external device space on the bus.
// - Addresses 2080 to 7FFF are program memory, internal or external.
// - Addresses 2000 to 207F are special-purpose memory, internal or external.
// - Addresses 0300 to 1EFF go to the external bus as device space.
// - Addresses 0100 to 02FF are upper register RAM, windowed direct allowed.
// - Addresses 0000 to 00FF are the lower register file, direct allowed.
package ebw_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [15:0] LOW_FILE_END   = 16'h00FF;
  localparam logic [15:0] UP_FILE_END    = 16'h02FF;
  localparam logic [15:0] EXT_LOW_END    = 16'h1EFF;
  localparam logic [15:0] PSFR_END       = 16'h1FDF;
  localparam logic [15:0] MSFR_END       = 16'h1FFF;
  localparam logic [15:0] SPECIAL_END    = 16'h207F;
  localparam logic [15:0] PROGRAM_END    = 16'h7FFF;
  localparam logic [15:0] RESET_VECTOR   = 16'h2080;

  // ****************************************
  // Configuration and timing
  // ****************************************
  localparam int          CFG_WR_SEL_BIT = 2;
  localparam logic [7:0]  CFG_RESET      = 8'hFF;
  localparam logic [1:0]  STROBE_LAST    = 2'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    RG_LOW_FILE, RG_UP_FILE, RG_EXT_LOW, RG_PSFR,
    RG_MSFR, RG_SPECIAL, RG_PROGRAM, RG_EXT_HIGH
  } ebw_region_t;

  typedef enum logic [1:0] {
    AM_DIRECT, AM_WINDOWED, AM_INDIRECT, AM_INDEXED
  } ebw_mode_t;

  typedef enum logic [1:0] {
    BS_IDLE, BS_ADDR, BS_STROBE, BS_END
  } ebw_bus_st_t;

endpackage

// ==== core/ebw_decode.sv ====
// Address region and addressing mode decoder.
`timescale 1ns/1ps
`default_nettype none
module ebw_decode
  import ebw_pkg::*;
(
  // Access
  input  wire logic [15:0] addr,
  input  wire logic [1:0]  mode,
  input  wire logic        ext_program,
  // Result
  output ebw_region_t      region,
  output logic             external,
  output logic             mode_ok
);

  always_comb begin
    if (addr <= LOW_FILE_END) begin
      region = RG_LOW_FILE;
    end else if (addr <= UP_FILE_END) begin
      region = RG_UP_FILE;
    end else if (addr <= EXT_LOW_END) begin
      region = RG_EXT_LOW;
    end else if (addr <= PSFR_END) begin
      region = RG_PSFR;
    end else if (addr <= MSFR_END) begin
      region = RG_MSFR;
    end else if (addr <= SPECIAL_END) begin
      region = RG_SPECIAL;
    end else if (addr <= PROGRAM_END) begin
      region = RG_PROGRAM;
    end else begin
      region = RG_EXT_HIGH;
    end
  end

  // Program and special memory go outside only when the external program strap is set.
  always_comb begin
    unique case (region)
      RG_EXT_LOW, RG_EXT_HIGH: external = 1'b1;
      RG_SPECIAL, RG_PROGRAM:  external = ext_program;
      default:                 external = 1'b0;
    endcase
  end

  always_comb begin
    unique case (region)
      RG_LOW_FILE:        mode_ok = (mode != AM_WINDOWED);
      RG_UP_FILE, RG_PSFR: mode_ok = (mode != AM_DIRECT);
      default:            mode_ok = (mode == AM_INDIRECT) || (mode == AM_INDEXED);
    endcase
  end

endmodule
`default_nettype wire

// ==== core/ebw_phase_div.sv ====
// Phase clock enable divider for normal and PLL bypass operation.
`timescale 1ns/1ps
`default_nettype none
module ebw_phase_div
  import ebw_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  input  wire logic bypass,
  // Enable
  output logic      phase_en
);

  typedef struct packed {
    logic tog;
    logic en;
  } ebw_div_state_t;

  ebw_div_state_t q;
  ebw_div_state_t d;

  // Without a real multiplier the normal mode runs one phase per input cycle.
  always_comb begin
    d = q;
    if (!run) begin
      d.tog = 1'b0;
      d.en  = 1'b0;
    end else if (bypass) begin
      d.tog = ~q.tog;
      d.en  = q.tog;
    end else begin
      d.tog = 1'b0;
      d.en  = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign phase_en = q.en;

endmodule
`default_nettype wire

// ==== core/ebw_top.sv ====
// External bus write strobe generator with address space decode.
`timescale 1ns/1ps
`default_nettype none
module ebw_top
  import ebw_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Chip configuration load
  input  wire logic        cfg_load,
  input  wire logic [7:0]  cfg_data,
  // Bus options
  input  wire logic        bus_16bit,
  input  wire logic        ext_program,
  // Core access request
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [15:0] acc_addr,
  input  wire logic [1:0]  acc_byte_en,
  input  wire logic [1:0]  acc_mode,
  // Core access answer
  output logic             acc_ready,
  output logic             acc_done,
  output logic             acc_mode_err,
  output ebw_region_t      acc_region,
  output logic             ext_cycle,
  // Boot fetch
  output logic             boot_fetch,
  output logic [15:0]      fetch_addr,
  // Clocking status
  output logic             clock_multiplier_strap,
  output logic             phase_en,
  output logic [7:0]       chip_config_0,
  // Shared write strobe pin
  input  wire logic        wr_pin_i,
  output logic             wr_pin_o,
  output logic             wr_pin_oe
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ebw_bus_st_t st;
    logic [1:0]  cnt;
    logic        strap_done;
    logic        bypass;
    logic [7:0]  cfg;
    logic        ready;
    logic        done;
    logic        mode_err;
    logic        strobe_req;
    ebw_region_t region;
    logic        ext;
    logic        pin_o;
    logic        pin_oe;
    logic        boot_pending;
    logic        boot_fetch;
    logic [15:0] fetch_addr;
  } ebw_top_state_t;

  localparam ebw_top_state_t TOP_RESET = '{
    st:           BS_IDLE,
    cnt:          2'h0,
    strap_done:   1'b0,
    bypass:       1'b0,
    cfg:          CFG_RESET,
    ready:        1'b0,
    done:         1'b0,
    mode_err:     1'b0,
    strobe_req:   1'b0,
    region:       RG_LOW_FILE,
    ext:          1'b0,
    pin_o:        1'b1,
    pin_oe:       1'b0,
    boot_pending: 1'b0,
    boot_fetch:   1'b0,
    fetch_addr:   16'h0000
  };

  ebw_top_state_t q;
  ebw_top_state_t d;
  ebw_region_t    dec_region;
  logic           dec_external;
  logic           dec_mode_ok;
  logic           div_en;
  logic           take;
  logic           want_strobe;

  // ****************************************
  // Submodules
  // ****************************************
  ebw_decode u_decode (
    .addr        (acc_addr),
    .mode        (acc_mode),
    .ext_program (ext_program),
    .region      (dec_region),
    .external    (dec_external),
    .mode_ok     (dec_mode_ok)
  );

  ebw_phase_div u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (q.strap_done),
    .bypass   (q.bypass),
    .phase_en (div_en)
  );

  // ****************************************
  // Next state
  // ****************************************
  assign take = div_en && q.ready && acc_valid && !q.boot_pending;

  // Strobe choice is fixed when the access is taken, so a config change mid-cycle is harmless.
  assign want_strobe = acc_write && dec_external && dec_mode_ok &&
                       (q.cfg[CFG_WR_SEL_BIT] || !bus_16bit || acc_byte_en[0]);

  always_comb begin
    d            = q;
    d.done       = 1'b0;
    d.mode_err   = 1'b0;
    d.boot_fetch = 1'b0;
    if (!q.strap_done) begin
      // The pin stays undriven until this first edge so the outside level can be read.
      d.strap_done   = 1'b1;
      d.bypass       = wr_pin_i;
      d.pin_oe       = 1'b1;
      d.pin_o        = 1'b1;
      d.boot_pending = 1'b1;
    end
    if (cfg_load) begin
      d.cfg = cfg_data;
    end
    if (div_en && q.boot_pending) begin
      d.boot_pending = 1'b0;
      d.boot_fetch   = 1'b1;
      d.fetch_addr   = RESET_VECTOR;
      d.ready        = 1'b1;
    end
    if (div_en) begin
      unique case (q.st)
        BS_IDLE: begin
          if (take) begin
            d.region     = dec_region;
            d.strobe_req = want_strobe;
            if (!dec_mode_ok) begin
              d.done     = 1'b1;
              d.mode_err = 1'b1;
            end else if (dec_external) begin
              d.st    = BS_ADDR;
              d.ext   = 1'b1;
              d.ready = 1'b0;
            end else begin
              d.done = 1'b1;
            end
          end
        end
        BS_ADDR: begin
          d.st    = BS_STROBE;
          d.cnt   = 2'h0;
          d.pin_o = ~q.strobe_req;
        end
        BS_STROBE: begin
          if (q.cnt == STROBE_LAST) begin
            d.st    = BS_END;
            d.pin_o = 1'b1;
          end else begin
            d.cnt = q.cnt + 2'h1;
          end
        end
        BS_END: begin
          d.st    = BS_IDLE;
          d.ext   = 1'b0;
          d.done  = 1'b1;
          d.ready = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= TOP_RESET;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign acc_ready              = q.ready;
  assign acc_done               = q.done;
  assign acc_mode_err           = q.mode_err;
  assign acc_region             = q.region;
  assign ext_cycle              = q.ext;
  assign boot_fetch             = q.boot_fetch;
  assign fetch_addr             = q.fetch_addr;
  assign clock_multiplier_strap = q.bypass;
  assign phase_en               = div_en;
  assign chip_config_0          = q.cfg;
  assign wr_pin_o               = q.pin_o;
  assign wr_pin_oe              = q.pin_oe;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_take_ext_wr;
    take && dec_external && dec_mode_ok && acc_write;
  endsequence

  sequence s_strobe_low;
    !wr_pin_o && wr_pin_oe;
  endsequence

  property p_strobe_only_in_write;
    s_strobe_low |-> (q.st == BS_STROBE) && q.strobe_req && q.ext;
  endproperty
  a_strobe_only_in_write: assert property (p_strobe_only_in_write)
    else $error("Write strobe low outside an external write cycle.");

  property p_strap_capture;
    $rose(q.strap_done) |-> clock_multiplier_strap == $past(wr_pin_i) && !$past(wr_pin_oe);
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("Clock strap not taken from the undriven pin level.");

  property p_bypass_half_rate;
    q.bypass && phase_en |=> !phase_en ##1 phase_en;
  endproperty
  a_bypass_half_rate: assert property (p_bypass_half_rate)
    else $error("Phase enable not at half rate in bypass mode.");

  property p_combined_strobe;
    s_take_ext_wr and q.cfg[CFG_WR_SEL_BIT] |-> ##[3:6] s_strobe_low;
  endproperty
  a_combined_strobe: assert property (p_combined_strobe)
    else $error("Combined strobe missing on an external write.");

  property p_no_high_only_strobe;
    s_take_ext_wr and !q.cfg[CFG_WR_SEL_BIT] and bus_16bit and acc_byte_en == 2'h2 |=>
      !q.strobe_req [*3];
  endproperty
  a_no_high_only_strobe: assert property (p_no_high_only_strobe)
    else $error("Low-byte strobe asserted for a high-byte-only write.");

  property p_byte_bus_strobe;
    s_take_ext_wr and !bus_16bit |=> q.strobe_req ##[2:5] s_strobe_low;
  endproperty
  a_byte_bus_strobe: assert property (p_byte_bus_strobe)
    else $error("Low-byte strobe missing on an 8-bit bus write.");

  property p_boot_vector;
    boot_fetch |-> fetch_addr == RESET_VECTOR && acc_region == RG_LOW_FILE && !ext_cycle;
  endproperty
  a_boot_vector: assert property (p_boot_vector)
    else $error("First fetch not from the reset vector.");

  property p_high_ext;
    take && dec_mode_ok && acc_addr[15] |=> acc_region == RG_EXT_HIGH && ext_cycle;
  endproperty
  a_high_ext: assert property (p_high_ext)
    else $error("Upper half not run as an external cycle.");

  property p_program_region;
    take && acc_addr >= RESET_VECTOR && acc_addr <= PROGRAM_END |=> acc_region == RG_PROGRAM;
  endproperty
  a_program_region: assert property (p_program_region)
    else $error("Program memory region misdecoded.");

  property p_msfr_no_window;
    take && acc_addr > PSFR_END && acc_addr <= MSFR_END && acc_mode == AM_WINDOWED |=>
      acc_mode_err && acc_done;
  endproperty
  a_msfr_no_window: assert property (p_msfr_no_window)
    else $error("Windowed access to memory-mapped registers not refused.");

  property p_internal_no_strobe;
    take && !dec_external |=> (acc_done && !ext_cycle && wr_pin_o) ##1 wr_pin_o;
  endproperty
  a_internal_no_strobe: assert property (p_internal_no_strobe)
    else $error("Strobe activity on an internal access.");

  property p_low_ext;
    take && dec_mode_ok && acc_addr > UP_FILE_END && acc_addr <= EXT_LOW_END |=>
      acc_region == RG_EXT_LOW && ext_cycle;
  endproperty
  a_low_ext: assert property (p_low_ext)
    else $error("Low device space not run as an external cycle.");

  property p_special_region;
    take && acc_addr > MSFR_END && acc_addr <= SPECIAL_END |=> acc_region == RG_SPECIAL;
  endproperty
  a_special_region: assert property (p_special_region)
    else $error("Special-purpose region misdecoded.");

  property p_low_file_direct;
    take && acc_addr <= LOW_FILE_END && acc_mode == AM_DIRECT |=>
      acc_done && !acc_mode_err && acc_region == RG_LOW_FILE && !ext_cycle;
  endproperty
  a_low_file_direct: assert property (p_low_file_direct)
    else $error("Direct access to the lower register file refused.");

endmodule
`default_nettype wire

// ==== sim/ebw_ext_dev.sv ====
// External memory device model that sits on the shared write strobe pin.
`timescale 1ns/1ps
`default_nettype none
module ebw_ext_dev
  import ebw_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Strap choice
  input  wire logic strap_hi,
  // Shared pin
  input  wire logic wr_pin_o,
  input  wire logic wr_pin_oe,
  output logic      wr_pin_i,
  // Observed writes
  output int        n_strobes
);
  // ****************************************
  // Strap drive and pin level
  // ****************************************
  logic hold_q;
  logic prev_q;

  // The strap is held through the first edge after release, so its capture never sees a released pin.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 1'b1;
    end else begin
      hold_q <= 1'b0;
    end
  end

  // A pull-up sets the level once neither side drives the pin.
  assign wr_pin_i = wr_pin_oe ? wr_pin_o : ((!rst_n || hold_q) ? strap_hi : 1'b1);

  // ****************************************
  // Write strobe counting
  // ****************************************
  initial n_strobes = 0;

  // A write lands on the rising end of a driven low strobe.
  always @(negedge core_clk) begin
    if (prev_q === 1'b0 && wr_pin_i === 1'b1 && wr_pin_oe === 1'b1) begin
      n_strobes++;
    end
    prev_q <= (wr_pin_oe === 1'b1) ? wr_pin_i : 1'b1;
  end
endmodule
`default_nettype wire

// ==== sim/test_ebw_top.sv ====
// Self-checking testbench for the external bus write strobe and address decode block.
`timescale 1ns/1ps
`default_nettype none
module test_ebw_top
  import ebw_pkg::*;
;
  typedef struct packed {
    ebw_region_t region;
    logic        err;
    logic        strobe;
  } ebw_exp_t;

  logic        core_clk, rst_n, cfg_load, bus_16bit, ext_program;
  logic        acc_valid, acc_write, strap_hi, cfg_sel, bypass;
  logic [7:0]  cfg_data;
  logic [15:0] acc_addr;
  logic [1:0]  acc_byte_en, acc_mode;
  logic        acc_ready, acc_done, acc_mode_err, ext_cycle, boot_fetch;
  logic        clock_multiplier_strap, phase_en, wr_pin_i, wr_pin_o, wr_pin_oe;
  logic [15:0] fetch_addr;
  logic [7:0]  chip_config_0;
  ebw_region_t acc_region;
  ebw_exp_t    exp_q[$];
  ebw_exp_t    w_exp;
  int          n_fail, n_compared, n_strobes, strobes_seen;
  logic [15:0] bnd [16] = '{16'h0000, 16'h00FF, 16'h0100, 16'h02FF, 16'h0300, 16'h1EFF, 16'h1F00, 16'h1FDF,
                            16'h1FE0, 16'h1FFF, 16'h2000, 16'h207F, 16'h2080, 16'h7FFF, 16'h8000, 16'hFFFF};

  ebw_top ebw_top_inst (.core_clk(core_clk), .rst_n(rst_n), .cfg_load(cfg_load), .cfg_data(cfg_data),
    .bus_16bit(bus_16bit), .ext_program(ext_program), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_byte_en(acc_byte_en), .acc_mode(acc_mode), .acc_ready(acc_ready),
    .acc_done(acc_done), .acc_mode_err(acc_mode_err), .acc_region(acc_region), .ext_cycle(ext_cycle),
    .boot_fetch(boot_fetch), .fetch_addr(fetch_addr), .clock_multiplier_strap(clock_multiplier_strap),
    .phase_en(phase_en), .chip_config_0(chip_config_0), .wr_pin_i(wr_pin_i), .wr_pin_o(wr_pin_o),
    .wr_pin_oe(wr_pin_oe));

  ebw_ext_dev ebw_ext_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .strap_hi(strap_hi), .wr_pin_o(wr_pin_o),
    .wr_pin_oe(wr_pin_oe), .wr_pin_i(wr_pin_i), .n_strobes(n_strobes));

  always #50 core_clk = ~core_clk;

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic final_report;
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic give_up(input string msg);
    check(1'b0, msg);
    final_report();
  endtask

  function automatic ebw_region_t exp_region(input logic [15:0] a);
    if (a <= 16'h00FF) return RG_LOW_FILE;
    if (a <= 16'h02FF) return RG_UP_FILE;
    if (a <= 16'h1EFF) return RG_EXT_LOW;
    if (a <= 16'h1FDF) return RG_PSFR;
    if (a <= 16'h1FFF) return RG_MSFR;
    if (a <= 16'h207F) return RG_SPECIAL;
    if (a <= 16'h7FFF) return RG_PROGRAM;
    return RG_EXT_HIGH;
  endfunction

  function automatic logic mode_ok(input ebw_region_t r, input logic [1:0] m);
    if (m >= 2'h2) return 1'b1;
    if (r == RG_LOW_FILE) return m == 2'h0;
    if (r == RG_UP_FILE || r == RG_PSFR) return m == 2'h1;
    return 1'b0;
  endfunction

  function automatic logic is_ext(input ebw_region_t r);
    return r == RG_EXT_LOW || r == RG_EXT_HIGH || (ext_program && (r == RG_SPECIAL || r == RG_PROGRAM));
  endfunction

  // ****************************************
  // Drivers
  // ****************************************
  task automatic do_reset(input logic strap);
    int i;
    @(posedge core_clk);
    rst_n <= 1'b0;
    strap_hi <= strap;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    cfg_sel = 1'b1;
    bypass = strap;
    for (i = 0; i < 12 && boot_fetch !== 1'b1; i++) @(negedge core_clk);
    if (boot_fetch !== 1'b1) give_up("no boot fetch");
    check(fetch_addr === 16'h2080, "boot fetch address");
    check(clock_multiplier_strap === strap, "strap capture");
  endtask

  task automatic phase_check;
    int i;
    int c;
    c = 0;
    for (i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (phase_en === 1'b1) c++;
    end
    check(c == (bypass ? 10 : 20), "phase enable rate");
  endtask

  task automatic set_cfg(input logic [7:0] v);
    @(posedge core_clk);
    cfg_load <= 1'b1;
    cfg_data <= v;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    cfg_sel = v[2];
    @(negedge core_clk);
    check(chip_config_0 === v, "configuration load");
  endtask

  task automatic access(input logic [15:0] a, input logic [1:0] m, input logic w, input logic [1:0] be);
    ebw_exp_t e;
    int i;
    @(posedge core_clk);
    e.region = exp_region(a);
    e.err = !mode_ok(e.region, m);
    e.strobe = w && !e.err && is_ext(e.region) && (cfg_sel || !bus_16bit || be[0]);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_mode <= m;
    acc_write <= w;
    acc_byte_en <= be;
    i = 0;
    do begin
      @(negedge core_clk);
      i++;
    end while (!(phase_en === 1'b1 && acc_ready === 1'b1) && i < 30);
    if (!(phase_en === 1'b1 && acc_ready === 1'b1)) give_up("request not taken");
    exp_q.push_back(e);
    @(posedge core_clk);
    acc_valid <= 1'b0;
    for (i = 0; i < 40 && exp_q.size() != 0; i++) @(negedge core_clk);
    if (exp_q.size() != 0) give_up("access never completed");
  endtask

  // ****************************************
  // Output watcher
  // ****************************************
  always @(negedge core_clk) begin
    if (wr_pin_oe === 1'b1 && wr_pin_o === 1'b0) check(ext_cycle === 1'b1, "strobe outside bus cycle");
    if (acc_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "completion without request");
      end else begin
        w_exp = exp_q.pop_front();
        check(acc_region === w_exp.region, "region");
        check(acc_mode_err === w_exp.err, "addressing mode");
        check((n_strobes - strobes_seen) == int'(w_exp.strobe), "write strobe");
      end
      strobes_seen = n_strobes;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    // Reset starts high so that its first fall is a real edge for every process.
    rst_n = 1'b1;
    cfg_load = 1'b0;
    cfg_data = 8'h00;
    bus_16bit = 1'b1;
    ext_program = 1'b0;
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = 16'h0000;
    acc_byte_en = 2'h3;
    acc_mode = 2'h0;
    strap_hi = 1'b0;
    void'($urandom(66));
    do_reset(1'b0);
    phase_check();
    $display("Test reset and boot done");
    for (int x = 0; x < 2; x++) begin
      @(posedge core_clk);
      ext_program <= x[0];
      for (int k = 0; k < 16; k++) begin
        for (int m = 0; m < 4; m++) access(bnd[k], m[1:0], 1'b1, 2'h3);
      end
    end
    $display("Test address map done");
    // Every lane and width is tried with both pin functions, reads included.
    for (int c = 0; c < 2; c++) begin
      set_cfg(c ? 8'hFF : 8'hFB);
      for (int b = 0; b < 2; b++) begin
        @(posedge core_clk);
        bus_16bit <= b[0];
        for (int be = 1; be < 4; be++) begin
          access({1'b1, 15'($urandom())}, 2'h2, 1'b1, be[1:0]);
          access({1'b1, 15'($urandom())}, 2'h3, 1'b0, be[1:0]);
        end
      end
    end
    $display("Test strobe selection done");
    do_reset(1'b1);
    phase_check();
    access(16'h9000, 2'h2, 1'b1, 2'h3);
    access(16'h0400, 2'h3, 1'b1, 2'h1);
    $display("Test bypass clocking done");
    do_reset(1'b0);
    access(16'h2080, 2'h2, 1'b1, 2'h3);
    $display("Test second reset done");
    final_report();
  end
endmodule
`default_nettype wire
